// ---- core/vta_defines.svh ----
`ifndef VTA_DEFINES_SVH
`define VTA_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define VTA_OFS_FLAGS 12'h400
`define VTA_OFS_UNTAG 12'h404
`define VTA_OFS_FWD 12'h408
`define VTA_OFS_INDEX 12'h40C
`define VTA_OFS_CMD 12'h40E
`define VTA_OFS_KEY_UP 12'h410
`define VTA_OFS_KEY_LO 12'h414

// ****************************************
// Field positions
// ****************************************
`define VTA_VALID_BIT 31
`define VTA_FWDSEL_BIT 27
`define VTA_PRIO_HI 26
`define VTA_PRIO_LO 24
`define VTA_MSTI_HI 14
`define VTA_MSTI_LO 12
`define VTA_FID_HI 6
`define VTA_FID_LO 0
`define VTA_MAP_HI 5
`define VTA_MAP_LO 0
`define VTA_INDEX_HI 11
`define VTA_INDEX_LO 0
`define VTA_START_BIT 7
`define VTA_ACT_HI 1
`define VTA_ACT_LO 0
`define VTA_KEY_RSV_BIT 31
`define VTA_LFK_HI 22
`define VTA_LFK_LO 16
`define VTA_LSK_HI 15
`define VTA_LSK_LO 0

// ****************************************
// Action codes and table size
// ****************************************
`define VTA_ACT_NOP 2'h0
`define VTA_ACT_WRITE 2'h1
`define VTA_ACT_READ 2'h2
`define VTA_ACT_CLEAR 2'h3
`define VTA_TABLE_DEPTH 4096
`define VTA_LAST_INDEX 12'hFFF
`define VTA_ZERO32 32'h0000_0000

`endif

// ---- core/vta_pkg.sv ----
package vta_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic valid;
    logic forward_select_bit;
    logic [2:0] prio_level;
    logic [2:0] spanning_instance;
    logic [6:0] filter_id;
    logic [5:0] untag_map;
    logic [5:0] forward_map;
  } vta_entry_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } vta_bus_req_t;

  typedef enum logic [2:0] {
    VTA_IDLE = 3'b001,
    VTA_READ = 3'b010,
    VTA_CLEAR = 3'b100
  } vta_state_t;

endpackage : vta_pkg

// ---- core/vta_table_access.sv ----
`include "vta_defines.svh"

module vta_table_access
  import vta_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire vta_bus_req_t bus_req,
  output logic [31:0] rdata,
  // Forwarding-side table lookup
  input wire logic [11:0] lookup_vid,
  output vta_entry_t lookup_entry,
  // Address lookup hashing key
  output logic [6:0] lookup_filter_key,
  output logic [47:0] lookup_station_key,
  // Status
  output logic table_busy
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ****************************************
  // State
  // ****************************************
  vta_entry_t stage;
  vta_entry_t next_stage;
  logic [11:0] vindex;
  logic [11:0] next_vindex;
  logic [1:0] action;
  logic [1:0] next_action;
  logic start;
  logic next_start;
  logic key_rsv;
  logic next_key_rsv;
  logic [6:0] next_lookup_filter_key;
  logic [47:0] next_lookup_station_key;
  vta_state_t state;
  vta_state_t next_state;
  logic [11:0] clr_idx;
  logic [11:0] next_clr_idx;
  logic [31:0] next_rdata;
  logic next_table_busy;

  // Table storage and its access signals
  vta_entry_t table_mem [0:`VTA_TABLE_DEPTH-1];
  vta_entry_t mem_rdata;
  vta_entry_t mem_wdata;
  logic [11:0] mem_waddr;
  logic mem_we;

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb begin
    next_rdata = `VTA_ZERO32;
    if (bus_req.rd) begin
      if (hit(bus_req.addr, `VTA_OFS_FLAGS)) begin
        next_rdata[`VTA_VALID_BIT] = stage.valid;
        next_rdata[`VTA_FWDSEL_BIT] = stage.forward_select_bit;
        next_rdata[`VTA_PRIO_HI:`VTA_PRIO_LO] = stage.prio_level;
        next_rdata[`VTA_MSTI_HI:`VTA_MSTI_LO] = stage.spanning_instance;
        next_rdata[`VTA_FID_HI:`VTA_FID_LO] = stage.filter_id;
      end else if (hit(bus_req.addr, `VTA_OFS_UNTAG)) begin
        next_rdata[`VTA_MAP_HI:`VTA_MAP_LO] = stage.untag_map;
      end else if (hit(bus_req.addr, `VTA_OFS_FWD)) begin
        next_rdata[`VTA_MAP_HI:`VTA_MAP_LO] = stage.forward_map;
      end else if (hit(bus_req.addr, `VTA_OFS_INDEX)) begin
        next_rdata[`VTA_INDEX_HI:`VTA_INDEX_LO] = vindex;
      end else if (hit(bus_req.addr, `VTA_OFS_CMD)) begin
        next_rdata[`VTA_START_BIT] = start;
        next_rdata[`VTA_ACT_HI:`VTA_ACT_LO] = action;
      end else if (hit(bus_req.addr, `VTA_OFS_KEY_UP)) begin
        next_rdata[`VTA_KEY_RSV_BIT] = key_rsv;
        next_rdata[`VTA_LFK_HI:`VTA_LFK_LO] = lookup_filter_key;
        next_rdata[`VTA_LSK_HI:`VTA_LSK_LO] = lookup_station_key[47:32];
      end else if (hit(bus_req.addr, `VTA_OFS_KEY_LO)) begin
        next_rdata = lookup_station_key[31:0];
      end
    end
  end

  // ****************************************
  // Register writes and table sequencer
  // ****************************************
  always_comb begin
    next_stage = stage;
    next_vindex = vindex;
    next_action = action;
    next_start = start;
    next_key_rsv = key_rsv;
    next_lookup_filter_key = lookup_filter_key;
    next_lookup_station_key = lookup_station_key;
    next_state = state;
    next_clr_idx = clr_idx;
    mem_we = 1'b0;
    mem_waddr = vindex;
    mem_wdata = stage;

    // Software writes
    if (bus_req.wr) begin
      if (hit(bus_req.addr, `VTA_OFS_FLAGS)) begin
        next_stage.valid = bus_req.wdata[`VTA_VALID_BIT];
        next_stage.forward_select_bit = bus_req.wdata[`VTA_FWDSEL_BIT];
        next_stage.prio_level = bus_req.wdata[`VTA_PRIO_HI:`VTA_PRIO_LO];
        next_stage.spanning_instance = bus_req.wdata[`VTA_MSTI_HI:`VTA_MSTI_LO];
        next_stage.filter_id = bus_req.wdata[`VTA_FID_HI:`VTA_FID_LO];
      end
      if (hit(bus_req.addr, `VTA_OFS_UNTAG)) begin
        next_stage.untag_map = bus_req.wdata[`VTA_MAP_HI:`VTA_MAP_LO];
      end
      if (hit(bus_req.addr, `VTA_OFS_FWD)) begin
        next_stage.forward_map = bus_req.wdata[`VTA_MAP_HI:`VTA_MAP_LO];
      end
      if (hit(bus_req.addr, `VTA_OFS_INDEX)) begin
        next_vindex = bus_req.wdata[`VTA_INDEX_HI:`VTA_INDEX_LO];
      end
      if (hit(bus_req.addr, `VTA_OFS_CMD)) begin
        next_action = bus_req.wdata[`VTA_ACT_HI:`VTA_ACT_LO];
      end
      if (hit(bus_req.addr, `VTA_OFS_KEY_UP)) begin
        next_key_rsv = bus_req.wdata[`VTA_KEY_RSV_BIT];
        next_lookup_filter_key = bus_req.wdata[`VTA_LFK_HI:`VTA_LFK_LO];
        next_lookup_station_key[47:32] = bus_req.wdata[`VTA_LSK_HI:`VTA_LSK_LO];
      end
      if (hit(bus_req.addr, `VTA_OFS_KEY_LO)) begin
        next_lookup_station_key[31:0] = bus_req.wdata;
      end
    end

    // Sequencer; relies on software holding its registers while busy
    case (state)
      VTA_IDLE: begin
        if (start) begin
          case (action)
            `VTA_ACT_WRITE: begin
              mem_we = 1'b1;
              mem_waddr = vindex;
              mem_wdata = stage;
              next_start = 1'b0;
            end
            `VTA_ACT_READ: begin
              next_state = VTA_READ;
            end
            `VTA_ACT_CLEAR: begin
              next_clr_idx = 12'h000;
              next_state = VTA_CLEAR;
            end
            default: begin
              next_start = 1'b0;
            end
          endcase
        end
      end
      VTA_READ: begin
        next_stage = mem_rdata;
        next_start = 1'b0;
        next_state = VTA_IDLE;
      end
      VTA_CLEAR: begin
        mem_we = 1'b1;
        mem_waddr = clr_idx;
        mem_wdata = '0;
        next_clr_idx = clr_idx + 12'h001;
        if (clr_idx == `VTA_LAST_INDEX) begin
          next_start = 1'b0;
          next_state = VTA_IDLE;
        end
      end
      default: begin
        next_state = VTA_IDLE;
        next_start = 1'b0;
      end
    endcase

    // A start written in the finishing cycle is kept
    if (bus_req.wr && hit(bus_req.addr, `VTA_OFS_CMD) && bus_req.wdata[`VTA_START_BIT]) begin
      next_start = 1'b1;
    end
    next_table_busy = next_start;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage <= '0;
      vindex <= 12'h000;
      action <= `VTA_ACT_NOP;
      start <= 1'b0;
      key_rsv <= 1'b0;
      lookup_filter_key <= 7'h00;
      lookup_station_key <= 48'h0000_0000_0000;
      state <= VTA_IDLE;
      clr_idx <= 12'h000;
      rdata <= `VTA_ZERO32;
      table_busy <= 1'b0;
    end else begin
      stage <= next_stage;
      vindex <= next_vindex;
      action <= next_action;
      start <= next_start;
      key_rsv <= next_key_rsv;
      lookup_filter_key <= next_lookup_filter_key;
      lookup_station_key <= next_lookup_station_key;
      state <= next_state;
      clr_idx <= next_clr_idx;
      rdata <= next_rdata;
      table_busy <= next_table_busy;
    end
  end

  // ****************************************
  // Table storage
  // ****************************************
  always_ff @(posedge clk) begin
    if (mem_we) begin
      table_mem[mem_waddr] <= mem_wdata;
    end
    mem_rdata <= table_mem[vindex];
  end

  // Entry presented to the forwarding logic, one cycle after the lookup
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lookup_entry <= '0;
    end else begin
      lookup_entry <= table_mem[lookup_vid];
    end
  end

endmodule : vta_table_access

// ---- tb/vta_assertions.sv ----
module vta_assertions
  import vta_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire vta_bus_req_t bus_req,
  input wire logic [31:0] rdata,
  // Lookup side and status
  input wire logic [11:0] lookup_vid,
  input wire vta_entry_t lookup_entry,
  input wire logic [6:0] lookup_filter_key,
  input wire logic [47:0] lookup_station_key,
  input wire logic table_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic go;
  logic [7:0] cmd;
  logic kup;
  logic klo;
  assign go = bus_req.wr && bus_req.addr == 12'h40E && !table_busy;
  assign cmd = bus_req.wdata[7:0];
  assign kup = bus_req.wr && bus_req.addr == 12'h410;
  assign klo = bus_req.wr && bus_req.addr == 12'h414;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 32'h0)
    else $error("read data not zero");
  a_start_readback: assert property ($past(bus_req.rd && bus_req.addr == 12'h40E) |->
    rdata[7] == $past(table_busy)) else $error("start bit readback wrong");
  a_nop_pulse: assert property (go && cmd == 8'h80 |=> table_busy ##1 !table_busy)
    else $error("idle action length wrong");
  a_write_pulse: assert property (go && cmd == 8'h81 |=> table_busy ##1 !table_busy)
    else $error("write action length wrong");
  a_read_span: assert property (go && cmd == 8'h82 |=> table_busy [*2] ##1 !table_busy)
    else $error("read action length wrong");
  a_clear_busy: assert property (go && cmd == 8'h83 |=> table_busy [*8])
    else $error("clear action ended early");
  a_filter_key: assert property (kup ##1 !kup |=> lookup_filter_key == $past(bus_req.wdata[22:16], 2))
    else $error("filter key wrong");
  a_station_upper: assert property (kup ##1 !kup |=>
    lookup_station_key[47:32] == $past(bus_req.wdata[15:0], 2)) else $error("upper station key wrong");
  a_station_lower: assert property (klo ##1 !klo |=>
    lookup_station_key[31:0] == $past(bus_req.wdata, 2)) else $error("lower station key wrong");
  c_clear: cover property (go && cmd == 8'h83);
  c_read: cover property (go && cmd == 8'h82);
  c_key: cover property (kup);
endmodule : vta_assertions
bind vta_table_access vta_assertions u_chk (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
  .lookup_vid(lookup_vid), .lookup_entry(lookup_entry), .lookup_filter_key(lookup_filter_key),
  .lookup_station_key(lookup_station_key), .table_busy(table_busy));

// ---- tb/tb.sv ----
module tb
  import vta_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  vta_bus_req_t req = '0;
  logic [11:0] vid = 12'h000;
  logic [31:0] rdata;
  vta_entry_t ent_q;
  logic [6:0] fkey;
  logic [47:0] skey;
  logic busy;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [11:0] ofs [7] = '{12'h400, 12'h404, 12'h408, 12'h40C, 12'h40E, 12'h410, 12'h414};
  logic [31:0] msk [7] = '{32'h8F00707F, 32'h3F, 32'h3F, 32'hFFF, 32'h0, 32'h807FFFFF, 32'hFFFFFFFF};
  always #5 clk = ~clk;
  vta_table_access DUT (.clk(clk), .resetn(resetn), .bus_req(req), .rdata(rdata), .lookup_vid(vid),
    .lookup_entry(ent_q), .lookup_filter_key(fkey), .lookup_station_key(skey), .table_busy(busy));
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rchk
  task automatic wait_done(input logic [31:0] exp);
    logic [31:0] d;
    d = 32'h80;
    for (int k = 0; k < 3000 && d[7]; k++) begin
      @(posedge clk);
      req.addr <= 12'h40E;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      d = rdata;
    end
    chk(d, exp);
  endtask : wait_done
  task automatic look(input logic [11:0] v, input logic [31:0] exp);
    @(posedge clk);
    vid <= v;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(ent_q), exp);
  endtask : look
  function automatic logic [31:0] ent(input logic [31:0] f, input logic [31:0] u, input logic [31:0] m);
    return {5'h0, f[31], f[27], f[26:24], f[14:12], f[6:0], u[5:0], m[5:0]};
  endfunction : ent
  task automatic stage(input logic [11:0] i, input logic [31:0] f, input logic [31:0] u, input logic [31:0] m);
    wr(12'h400, f);
    wr(12'h404, u);
    wr(12'h408, m);
    wr(12'h40C, {20'h0, i});
    wr(12'h40E, 32'h81);
    wait_done(32'h1);
  endtask : stage
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    wr(12'h418, 32'hFFFFFFFF);
    foreach (ofs[i]) rchk(ofs[i], 32'h0);
    rchk(12'h418, 32'h0);
    foreach (ofs[i]) if (i != 4) wr(ofs[i], 32'hFFFFFFFF);
    foreach (ofs[i]) if (i != 4) rchk(ofs[i], msk[i]);
    chk(32'(fkey), 32'h7F);
    chk(32'(skey[47:32]), 32'hFFFF);
    chk(skey[31:0], 32'hFFFFFFFF);
    $display("register test done");
    stage(12'h005, 32'h83005055, 32'h21, 32'h12);
    stage(12'h006, 32'h0C002011, 32'h1E, 32'h2D);
    stage(12'hFFF, 32'h83005055, 32'h1E, 32'h12);
    look(12'h005, ent(32'h83005055, 32'h21, 32'h12));
    look(12'h006, ent(32'h0C002011, 32'h1E, 32'h2D));
    look(12'hFFF, ent(32'h83005055, 32'h1E, 32'h12));
    wr(12'h40C, 32'h5);
    wr(12'h40E, 32'h82);
    wait_done(32'h2);
    rchk(12'h400, 32'h83005055);
    rchk(12'h404, 32'h21);
    rchk(12'h408, 32'h12);
    $display("action test done");
    wr(12'h40E, 32'h80);
    wait_done(32'h0);
    rchk(12'h404, 32'h21);
    wr(12'h40E, 32'h83);
    wait_done(32'h3);
    look(12'h005, 32'h0);
    look(12'hFFF, 32'h0);
    rchk(12'h400, 32'h83005055);
    $display("clear test done");
    tally_and_finish();
  end
endmodule : tb
